/* logic/adc_seq_pkg.sv */
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TICKS = 13;
  localparam int EXT_ACQ_TICKS = 3;
  localparam int INT_CONV_TIME_NS = 3600;
  // Longest time: rounded down to whole cycles
  localparam int INT_TICK_CYCLES = INT_CONV_TIME_NS / (CONV_TICKS * CLK_PERIOD_NS);
  localparam int INT_ACQ_TIME_NS = 1000;
  // Least time: rounded up to whole cycles
  localparam int INT_ACQ_CYCLES = (INT_ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RESULT_W = 10;
  localparam int CTRL_W = 8;
  localparam int CNT_W = 8;
  localparam int TICK_W = 4;

  // ----------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------
  localparam int POWER_MODE_HI_BIT = 7;
  localparam int POWER_MODE_LO_BIT = 6;
  localparam int ACQ_TIMING_BIT = 5;
  localparam int SINGLE_ENDED_BIT = 4;
  localparam int UNIPOLAR_BIT = 3;
  localparam int CHANNEL_ADDR_MSB = 2;
  localparam int CHANNEL_ADDR_LSB = 0;

  // Normal operation with external clock, unipolar, channel 0
  localparam logic [7:0] CTRL_RESET = 8'hc8;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ_INT,
    ST_ACQ_EXT,
    ST_CONV
  } seq_state_t;

endpackage : adc_seq_pkg

/* logic/adc_conversion_sequencer.sv */
`timescale 1ns/10ps
// How it works
// R1: A written control byte picks channel and polarity and starts the sequence.
// R2: Write rising edge with chip select starts acquisition, or acquisition then conversion.
// R3: Conversion lasts exactly 13 conversion clock ticks in every mode.
// R4: A write during conversion aborts it and starts a new acquisition.
// R5: Internal acquisition lasts three external ticks or about 1 us internal, then converts.
// R6: Write with acquisition bit set acquires until the next write.
// R7: Second write with acquisition bit clear starts conversion at write rising edge.
// R8: Host keeps channel address identical on both external acquisition writes.
// R9: Power mode bits may change on the second write without disturbing conversion.
// R10: Host changes no other control bits on the second write.
// R11: Completion interrupt goes low when conversion ends and result is ready.
// R12: Interrupt returns high on first read or on a new write.
// R13: Power-down codes keep the most recently requested clock mode.
// R14: After reset the block runs in external clock mode.
// R15: Both acquisition timings work with both clock sources.
// R16: Bits 7..6: 00 full down, 01 standby, 10 internal clock, 11 external.
// R17: Bit 5 clear gives internal acquisition, set gives host-timed acquisition.
// R18: Bit 4 set selects single-ended, clear selects pseudo-differential input.
// R19: Bit 3 clear selects bipolar, set selects unipolar range.
// R20: Bits 2..0 form the channel address.
// R21: Result is straight binary unipolar, two's complement bipolar.
// R22: Low byte with byte select low; else top two bits, zero or sign filled.
// R23: Chip select high ignores clock, write, read and floats the bus.
// R24: Result is latched into a holding register before the interrupt falls.
module adc_conversion_sequencer #(
  parameter int INT_TICK_CYCLES = adc_seq_pkg::INT_TICK_CYCLES,
  parameter int INT_ACQ_CYCLES = adc_seq_pkg::INT_ACQ_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CS_N_IN,
  input wire logic WR_N_IN,
  input wire logic RD_N_IN,
  input wire logic CONV_CLK_PIN_IN,
  input wire logic HIGH_BYTE_SELECT_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic COMPARATOR_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_N_OUT,
  output logic INT_N_OUT,
  output logic TRACK_OUT,
  output logic CONVERTING_OUT,
  output logic [9:0] DAC_CODE_OUT,
  output logic [2:0] CHANNEL_ADDR_OUT,
  output logic SINGLE_ENDED_OUT,
  output logic UNIPOLAR_OUT,
  output logic [1:0] POWER_MODE_OUT,
  output logic INTERNAL_CLOCK_OUT
);

  localparam logic [7:0] INT_TICK_LAST = 8'(INT_TICK_CYCLES - 1);
  localparam logic [7:0] INT_ACQ_LAST = 8'(INT_ACQ_CYCLES - 1);
  localparam logic [7:0] EXT_ACQ_LAST = 8'(adc_seq_pkg::EXT_ACQ_TICKS - 1);
  localparam logic [3:0] CONV_LAST = 4'(adc_seq_pkg::CONV_TICKS - 1);
  localparam logic [3:0] SAR_LAST = 4'(adc_seq_pkg::RESULT_W - 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] bus_byte(input logic [9:0] res, input logic hi,
                                          input logic uni);
    logic [7:0] b;
    b = res[7:0];
    if (hi) begin
      b = {{6{res[9] & ~uni}}, res[9:8]};
    end
    return b;
  endfunction : bus_byte

  function automatic logic normal_mode(input logic [7:0] ctrl);
    return ctrl[adc_seq_pkg::POWER_MODE_HI_BIT];
  endfunction : normal_mode

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  logic wr_n_prev_reg;
  logic conv_clk_prev_reg;
  logic rd_act_prev_reg;
  logic [7:0] int_div_reg;
  logic [7:0] int_div_next;
  logic write_strobe;
  logic ext_edge;
  logic read_start;
  logic rd_act;
  logic int_tick;

  assign rd_act = ~CS_N_IN & ~RD_N_IN;
  // Control byte is taken at the write rising edge, while chip select is low
  assign write_strobe = ~CS_N_IN & ~wr_n_prev_reg & WR_N_IN; // [R2] [R23]
  assign ext_edge = ~CS_N_IN & ~conv_clk_prev_reg & CONV_CLK_PIN_IN; // [R23]
  assign read_start = rd_act & ~rd_act_prev_reg;
  assign int_tick = (int_div_reg == INT_TICK_LAST);

  always_comb begin
    int_div_next = int_div_reg + 8'h01;
    if (int_tick) begin
      int_div_next = 8'h00;
    end
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_n_prev_reg <= 1'b1;
      conv_clk_prev_reg <= 1'b0;
      rd_act_prev_reg <= 1'b0;
      int_div_reg <= 8'h00;
    end else begin
      wr_n_prev_reg <= WR_N_IN;
      conv_clk_prev_reg <= CONV_CLK_PIN_IN;
      rd_act_prev_reg <= rd_act;
      int_div_reg <= int_div_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  adc_seq_pkg::seq_state_t state_reg;
  adc_seq_pkg::seq_state_t state_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic ext_clk_reg;
  logic ext_clk_next;
  logic [7:0] acq_cnt_reg;
  logic [7:0] acq_cnt_next;
  logic [3:0] tick_cnt_reg;
  logic [3:0] tick_cnt_next;
  logic [9:0] sar_reg;
  logic [9:0] sar_next;
  logic [9:0] result_reg;
  logic [9:0] result_next;
  logic int_n_reg;
  logic int_n_next;
  logic int_clk_reg;
  logic int_clk_next;
  logic conv_tick;
  logic acq_step;
  logic [7:0] acq_last;
  logic conv_done;
  logic [3:0] sar_bit;

  // Either source drives the same counters, so all four mode pairs work
  assign conv_tick = ext_clk_reg ? ext_edge : int_tick; // [R15]
  assign acq_step = ext_clk_reg ? ext_edge : 1'b1;
  assign acq_last = ext_clk_reg ? EXT_ACQ_LAST : INT_ACQ_LAST;
  assign conv_done = (state_reg == adc_seq_pkg::ST_CONV) & conv_tick &
                     (tick_cnt_reg == CONV_LAST) & ~write_strobe;
  assign sar_bit = SAR_LAST - tick_cnt_reg;

  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    ext_clk_next = ext_clk_reg;
    acq_cnt_next = acq_cnt_reg;
    tick_cnt_next = tick_cnt_reg;
    sar_next = sar_reg;
    result_next = result_reg;
    int_n_next = int_n_reg;
    if (read_start) begin
      int_n_next = 1'b1; // [R12]
    end
    if (write_strobe) begin
      ctrl_next = DATA_IN; // [R1] [R17] [R18] [R19] [R20]
      int_n_next = 1'b1; // [R12]
      if (DATA_IN[adc_seq_pkg::POWER_MODE_HI_BIT]) begin
        ext_clk_next = DATA_IN[adc_seq_pkg::POWER_MODE_LO_BIT]; // [R16]
      end
      // Power-down codes leave the clock source as it was [R13]
      if ((state_reg == adc_seq_pkg::ST_ACQ_EXT) &&
          !DATA_IN[adc_seq_pkg::ACQ_TIMING_BIT]) begin
        // Second write converts even if it also changes the power bits
        state_next = adc_seq_pkg::ST_CONV; // [R7] [R9]
        tick_cnt_next = 4'h0;
        sar_next = adc_seq_pkg::SAR_FIRST_TRIAL;
      end else if (normal_mode(DATA_IN)) begin
        acq_cnt_next = 8'h00;
        if (DATA_IN[adc_seq_pkg::ACQ_TIMING_BIT]) begin
          state_next = adc_seq_pkg::ST_ACQ_EXT; // [R6] [R4]
        end else begin
          state_next = adc_seq_pkg::ST_ACQ_INT; // [R2] [R4]
        end
      end else begin
        state_next = adc_seq_pkg::ST_IDLE;
      end
    end else begin
      unique case (state_reg)
        adc_seq_pkg::ST_IDLE: begin
        end
        adc_seq_pkg::ST_ACQ_EXT: begin
        end
        adc_seq_pkg::ST_ACQ_INT: begin
          if (acq_step) begin
            acq_cnt_next = acq_cnt_reg + 8'h01;
            if (acq_cnt_reg == acq_last) begin
              state_next = adc_seq_pkg::ST_CONV; // [R5]
              tick_cnt_next = 4'h0;
              sar_next = adc_seq_pkg::SAR_FIRST_TRIAL;
            end
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (conv_tick) begin
            tick_cnt_next = tick_cnt_reg + 4'h1;
            if (tick_cnt_reg <= SAR_LAST) begin
              sar_next[sar_bit] = COMPARATOR_IN;
              if (sar_bit != 4'h0) begin
                sar_next[sar_bit - 4'h1] = 1'b1;
              end
            end
            if (tick_cnt_reg == CONV_LAST) begin
              // Bipolar only: offset code to two's complement by flipping the sign bit
              result_next = {sar_reg[9] ^ ~ctrl_reg[adc_seq_pkg::UNIPOLAR_BIT],
                             sar_reg[8:0]}; // [R21] [R24]
              int_n_next = 1'b0; // [R3] [R11]
              state_next = adc_seq_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
    // Own flop so the clock mode pin comes straight from a register
    int_clk_next = ~ext_clk_next; // [R13] [R14]
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_reg <= adc_seq_pkg::ST_IDLE;
      ctrl_reg <= adc_seq_pkg::CTRL_RESET;
      ext_clk_reg <= 1'b1; // [R14]
      acq_cnt_reg <= 8'h00;
      tick_cnt_reg <= 4'h0;
      sar_reg <= adc_seq_pkg::RESULT_RESET;
      result_reg <= adc_seq_pkg::RESULT_RESET;
      int_n_reg <= 1'b1;
      int_clk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      ext_clk_reg <= ext_clk_next;
      acq_cnt_reg <= acq_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      sar_reg <= sar_next;
      result_reg <= result_next;
      int_n_reg <= int_n_next;
      int_clk_reg <= int_clk_next;
    end
  end

  // ----------------------------------------------------------------
  // Read port and status outputs
  // ----------------------------------------------------------------
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic track_reg;
  logic track_next;
  logic conv_reg;
  logic conv_next;

  always_comb begin
    data_next = data_reg;
    oe_n_next = 1'b1; // [R23]
    if (rd_act) begin
      data_next = bus_byte(result_reg, HIGH_BYTE_SELECT_IN,
                           ctrl_reg[adc_seq_pkg::UNIPOLAR_BIT]); // [R22]
      oe_n_next = 1'b0;
    end
    track_next = (state_next == adc_seq_pkg::ST_ACQ_INT) ||
                 (state_next == adc_seq_pkg::ST_ACQ_EXT);
    conv_next = (state_next == adc_seq_pkg::ST_CONV);
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      data_reg <= adc_seq_pkg::BYTE_ZERO;
      oe_n_reg <= 1'b1;
      track_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      oe_n_reg <= oe_n_next;
      track_reg <= track_next;
      conv_reg <= conv_next;
    end
  end

  assign DATA_OUT = data_reg;
  assign DATA_OE_N_OUT = oe_n_reg;
  assign INT_N_OUT = int_n_reg;
  assign TRACK_OUT = track_reg;
  assign CONVERTING_OUT = conv_reg;
  assign DAC_CODE_OUT = sar_reg;
  assign CHANNEL_ADDR_OUT = ctrl_reg[adc_seq_pkg::CHANNEL_ADDR_MSB:adc_seq_pkg::CHANNEL_ADDR_LSB];
  assign SINGLE_ENDED_OUT = ctrl_reg[adc_seq_pkg::SINGLE_ENDED_BIT];
  assign UNIPOLAR_OUT = ctrl_reg[adc_seq_pkg::UNIPOLAR_BIT];
  assign POWER_MODE_OUT = ctrl_reg[adc_seq_pkg::POWER_MODE_HI_BIT:adc_seq_pkg::POWER_MODE_LO_BIT];
  assign INTERNAL_CLOCK_OUT = int_clk_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  AST_WRITE_STARTS: assert property ( // [R2]
    write_strobe && DATA_IN[7] && (state_reg != adc_seq_pkg::ST_ACQ_EXT) |=>
    TRACK_OUT && (state_reg == ($past(DATA_IN[5]) ? adc_seq_pkg::ST_ACQ_EXT :
                                adc_seq_pkg::ST_ACQ_INT)))
    else $error("write did not start acquisition");
  AST_CONV_DONE: assert property ( // [R3]
    conv_done |=> (state_reg == adc_seq_pkg::ST_IDLE) && !INT_N_OUT)
    else $error("conversion did not end after thirteen ticks");
  AST_TICK_BOUND: assert property ( // [R3]
    (state_reg == adc_seq_pkg::ST_CONV) |-> (tick_cnt_reg <= CONV_LAST))
    else $error("conversion ran past thirteen ticks");
  AST_ABORT: assert property ( // [R4]
    (state_reg == adc_seq_pkg::ST_CONV) && write_strobe && DATA_IN[7] |=>
    (state_reg != adc_seq_pkg::ST_CONV) && TRACK_OUT && INT_N_OUT)
    else $error("write during conversion did not restart acquisition");
  AST_INT_ACQ_EXT: assert property ( // [R5]
    (state_reg == adc_seq_pkg::ST_ACQ_INT) && ext_clk_reg && ext_edge &&
    (acq_cnt_reg == EXT_ACQ_LAST) && !write_strobe |=> CONVERTING_OUT && (tick_cnt_reg == 4'h0))
    else $error("internal acquisition not three external ticks");
  AST_EXT_ACQ_HOLD: assert property ( // [R6]
    (state_reg == adc_seq_pkg::ST_ACQ_EXT) && !write_strobe |=>
    (state_reg == adc_seq_pkg::ST_ACQ_EXT) && TRACK_OUT)
    else $error("external acquisition ended without a write");
  AST_SECOND_WRITE: assert property ( // [R7]
    (state_reg == adc_seq_pkg::ST_ACQ_EXT) && write_strobe && !DATA_IN[5] |=>
    CONVERTING_OUT && (POWER_MODE_OUT == $past(DATA_IN[7:6])))
    else $error("second write did not start conversion");
  AST_INT_CLEAR: assert property ( // [R12]
    !INT_N_OUT && (read_start || write_strobe) && !conv_done |=> INT_N_OUT)
    else $error("interrupt not released by read or write");
  AST_CLOCK_KEEP: assert property ( // [R13]
    write_strobe && !DATA_IN[7] |=> $stable(INTERNAL_CLOCK_OUT))
    else $error("power-down write changed clock mode");
  AST_BUS_FLOAT: assert property ( // [R23]
    CS_N_IN |=> DATA_OE_N_OUT)
    else $error("bus driven while chip select high");

  CVR_INT_ACQ_CONV: cover property (
    (state_reg == adc_seq_pkg::ST_ACQ_INT) ##1 CONVERTING_OUT [*2] ##[1:1000] !INT_N_OUT);
  CVR_EXT_ACQ_CONV: cover property (
    (state_reg == adc_seq_pkg::ST_ACQ_EXT) && write_strobe && !DATA_IN[5]);
  CVR_ABORT: cover property ((state_reg == adc_seq_pkg::ST_CONV) && write_strobe);
  CVR_READ_HIGH: cover property (!INT_N_OUT && read_start && HIGH_BYTE_SELECT_IN);

endmodule : adc_conversion_sequencer

/* verification/host_bus_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side of the parallel port and the conversion clock source
// ----------------------------------------------------------------
module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] bus_in,
  input wire logic bus_oe_n_in,
  output logic cs_n_out,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic conv_clk_out,
  output logic high_byte_select_out,
  output logic [7:0] data_out,
  output logic cmp_out
);
  initial begin
    cs_n_out = 1'b0;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    conv_clk_out = 1'b0;
    high_byte_select_out = 1'b0;
    data_out = 8'h00;
    cmp_out = 1'b0;
  end

  // Caller keeps channel, single-ended and unipolar bits equal on both acquisition writes
  task automatic write_byte(input logic [7:0] d);
    @(posedge clk_in);
    wr_n_out <= 1'b0;
    data_out <= d;
    @(posedge clk_in);
    wr_n_out <= 1'b1;
    @(posedge clk_in);
    // Released bus shows the inverse so a stale value is never trusted
    data_out <= ~d;
  endtask : write_byte

  task automatic read_byte(input logic hb, output logic [7:0] d, output logic oe_n);
    @(posedge clk_in);
    rd_n_out <= 1'b0;
    high_byte_select_out <= hb;
    repeat (2) @(posedge clk_in);
    d = bus_in;
    oe_n = bus_oe_n_in;
    rd_n_out <= 1'b1;
  endtask : read_byte

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      conv_clk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      conv_clk_out <= 1'b0;
      @(posedge clk_in);
    end
  endtask : tick

  task automatic set_lines(input logic cs_n, input logic cmp);
    @(posedge clk_in);
    cs_n_out <= cs_n;
    cmp_out <= cmp;
  endtask : set_lines
endmodule : host_bus_model

/* verification/adc_conversion_sequencer_tb.sv */
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
  logic mclk, arst_n;
  wire logic cs_n, wr_n, rd_n, cclk, hbs, cmp;
  wire logic [7:0] din, dout;
  logic [7:0] d;
  wire logic oe_n, int_n, track, conv, se, uni, ic;
  logic o;
  wire logic [9:0] dac;
  wire logic [2:0] ch;
  wire logic [1:0] pm;
  int err_total;
  int n_tests;

  // Short internal counts keep the run brief
  adc_conversion_sequencer #(.INT_TICK_CYCLES(4), .INT_ACQ_CYCLES(3)) uut (
    .MCLK_IN(mclk), .ARST_N_IN(arst_n), .CS_N_IN(cs_n), .WR_N_IN(wr_n),
    .RD_N_IN(rd_n), .CONV_CLK_PIN_IN(cclk), .HIGH_BYTE_SELECT_IN(hbs),
    .DATA_IN(din), .COMPARATOR_IN(cmp), .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n),
    .INT_N_OUT(int_n), .TRACK_OUT(track), .CONVERTING_OUT(conv), .DAC_CODE_OUT(dac),
    .CHANNEL_ADDR_OUT(ch), .SINGLE_ENDED_OUT(se), .UNIPOLAR_OUT(uni),
    .POWER_MODE_OUT(pm), .INTERNAL_CLOCK_OUT(ic)
  );

  host_bus_model host (
    .clk_in(mclk), .bus_in(dout), .bus_oe_n_in(oe_n), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .conv_clk_out(cclk),
    .high_byte_select_out(hbs), .data_out(din), .cmp_out(cmp)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(10'(int_n), 10'h001);
    chk(10'(ic), 10'h000);
    chk(10'(oe_n), 10'h001);
  endtask : t_reset

  task automatic t_int_acq_ext_clk;
    host.set_lines(1'b0, 1'b1);
    host.write_byte(8'hcb);
    #1;
    chk(10'(track), 10'h001);
    chk(10'({pm, se, uni, ch}), 10'h06b);
    host.tick(2);
    #1;
    chk(10'(track), 10'h001);
    host.tick(1);
    repeat (2) @(posedge mclk);
    #1;
    chk(10'({track, conv}), 10'h001);
    chk(dac, 10'h200);
    host.tick(12);
    #1;
    chk(10'(int_n), 10'h001);
    chk(dac, 10'h3ff);
    host.tick(1);
    repeat (2) @(posedge mclk);
    #1;
    chk(10'(int_n), 10'h000);
    host.read_byte(1'b0, d, o);
    chk(10'(d), 10'h0ff);
    chk(10'(o), 10'h000);
    #1;
    chk(10'(int_n), 10'h001);
    host.read_byte(1'b1, d, o);
    chk(10'(d), 10'h003);
  endtask : t_int_acq_ext_clk

  task automatic t_int_clk_bipolar;
    host.set_lines(1'b0, 1'b0);
    host.write_byte(8'h80);
    #1;
    chk(10'(ic), 10'h001);
    for (int i = 0; i < 300 && int_n !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(10'(int_n), 10'h000);
    chk(dac, 10'h000);
    host.read_byte(1'b0, d, o);
    chk(10'(d), 10'h000);
    host.read_byte(1'b1, d, o);
    chk(10'(d), 10'h0fe);
    host.write_byte(8'h00);
    repeat (4) @(posedge mclk);
    #1;
    chk(10'({ic, track, conv}), 10'h004);
  endtask : t_int_clk_bipolar

  task automatic t_ext_acq;
    host.set_lines(1'b0, 1'b1);
    host.write_byte(8'he8);
    host.tick(6);
    #1;
    chk(10'({track, conv}), 10'h002);
    host.write_byte(8'h48);
    #1;
    chk(10'({track, conv}), 10'h001);
    chk(10'({pm, ic}), 10'h002);
    host.tick(13);
    repeat (2) @(posedge mclk);
    #1;
    chk(10'(int_n), 10'h000);
  endtask : t_ext_acq

  task automatic t_abort;
    host.write_byte(8'hc8);
    #1;
    chk(10'(int_n), 10'h001);
    host.tick(8);
    #1;
    chk(10'(conv), 10'h001);
    host.write_byte(8'hc8);
    #1;
    chk(10'({track, conv}), 10'h002);
    host.tick(16);
    repeat (2) @(posedge mclk);
    #1;
    chk(10'(int_n), 10'h000);
  endtask : t_abort

  task automatic t_cs_high;
    host.set_lines(1'b1, 1'b1);
    host.write_byte(8'hc8);
    host.tick(20);
    host.read_byte(1'b0, d, o);
    #1;
    chk(10'({o, int_n, track, conv}), 10'h008);
    host.set_lines(1'b0, 1'b1);
  endtask : t_cs_high

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    arst_n = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_int_acq_ext_clk();
    t_int_clk_bipolar();
    t_ext_acq();
    t_abort();
    t_cs_high();
    report_and_stop();
  end
endmodule : adc_conversion_sequencer_tb
